// ===== design/ppd_pkg.sv
// package for the program space page decoder
// assumes a 12-bit program counter and an 8-bit data bus from the core
package ppd_pkg;
    localparam int          PROG_CNT_W    = 12;
    localparam int          PHYS_W        = 13;
    localparam int          PAGE_W        = 2;
    localparam int          OFS_W         = 11;
    localparam int          TOP_BIT       = 11;
    localparam logic [1:0]  STATIC_PAGE   = 2'h1;
    localparam logic [7:0]  PAGE_SEL_ADDR = 8'hca;
    localparam logic [11:0] IRQ_VEC_LO    = 12'hff0;
    localparam logic [11:0] IRQ_VEC_HI    = 12'hff7;
    localparam logic [11:0] NMI_VEC_LO    = 12'hffc;
    localparam logic [11:0] NMI_VEC_HI    = 12'hffd;
    localparam int          STACK_DEPTH   = 6;
    localparam logic [2:0]  STACK_CNT_W1  = 3'h6;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  data;
    } ppd_dwrite_t;

    typedef struct packed {
        logic        push;
        logic        pop;
        logic [11:0] data;
    } ppd_stack_req_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_RUN   = 3'b010,
        ST_PROG  = 3'b100
    } ppd_mode_t;
endpackage

// ===== design/ppd_decoder.sv
// program space page decoder with return stack, nmi edge and mode capture
// assumes core writes data space on one cycle strobes; pins are asynchronous
// Notes on behaviour
// - program address is a 12-bit counter covering 4 KB
// - physical memory is four 2 KB pages, page 1 static
// - lower range 000h-7FFh reaches the page chosen by page select
// - top bit set: 0800h-0FFFh always reaches the static page
// - static page also reachable in lower window, same storage
// - maskable vectors 0FF0h-0FF7h, nmi vector 0FFCh-0FFDh in static page
// - falling edge on nmi input raises a non-maskable request
// - low reset pin restarts the controller
// - test pin high during reset enters programming mode
// - return stack holds six levels
// - two-bit select: 00 page0, 01 static, 10 page2, 11 page3
// - select is write-only at CAh, no bit ops, cleared to 00 by I_RST
`timescale 1ns/10ps
module ppd_decoder
    import ppd_pkg::*;
(
    input  wire logic                           I_MCLK,
    input  wire logic                           I_RST,
    input  wire logic                           I_CE,
    input  wire logic [ppd_pkg::PROG_CNT_W-1:0] I_PROGRAM_COUNTER,
    input  wire ppd_pkg::ppd_dwrite_t           I_DWRITE,
    input  wire ppd_pkg::ppd_stack_req_t        I_STACK,
    input  wire logic                           I_NMI_N,
    input  wire logic                           I_RESET_N,
    input  wire logic                           I_TEST,
    input  wire logic                           I_NMI_ACK,
    output logic [ppd_pkg::PHYS_W-1:0]          O_PHYS_ADDR,
    output logic                                O_IRQ_VEC,
    output logic                                O_NMI_VEC,
    output logic                                O_NMI_REQ,
    output logic                                O_CORE_RESET,
    output logic                                O_PROG_MODE,
    output logic [ppd_pkg::PROG_CNT_W-1:0]      O_STACK_TOP,
    output logic                                O_STACK_OVF,
    output logic                                O_STACK_UNF
);
    import ppd_pkg::*;

    logic [PAGE_W-1:0]     program_page_select;
    logic [2:0]            nmi_sync;
    logic [2:0]            rst_sync;
    logic [2:0]            tst_sync;
    logic                  nmi_lvl;
    logic                  rst_lvl;
    logic [PROG_CNT_W-1:0] stack_mem [STACK_DEPTH];
    logic [2:0]            stack_cnt;
    ppd_mode_t             mode;

    wire               program_counter_top_bit = I_PROGRAM_COUNTER[TOP_BIT];
    wire [PAGE_W-1:0]  eff_page = program_counter_top_bit ? STATIC_PAGE
                                                          : program_page_select;
    wire [PHYS_W-1:0]  next_phys = {eff_page, I_PROGRAM_COUNTER[OFS_W-1:0]};
    wire               sel_wr = I_DWRITE.wr && (I_DWRITE.addr == PAGE_SEL_ADDR);
    wire               nmi_agree = (nmi_sync[2] == nmi_sync[1]);
    wire               nmi_fall = nmi_agree && !nmi_sync[1] && nmi_lvl;
    wire               rst_agree = (rst_sync[2] == rst_sync[1]);
    wire               tst_agree = (tst_sync[2] == tst_sync[1]);
    wire               do_push = I_STACK.push && (stack_cnt != STACK_CNT_W1);
    wire               do_pop = I_STACK.pop && !I_STACK.push && (stack_cnt != 3'h0);
    wire               next_irq = (I_PROGRAM_COUNTER >= IRQ_VEC_LO)
                                  && (I_PROGRAM_COUNTER <= IRQ_VEC_HI);
    wire               next_nmiv = (I_PROGRAM_COUNTER >= NMI_VEC_LO)
                                  && (I_PROGRAM_COUNTER <= NMI_VEC_HI);

    // page select write; stored bits are the low two of the byte
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            program_page_select <= 2'h0;
        end else if (I_CE && sel_wr) begin
            program_page_select <= I_DWRITE.data[PAGE_W-1:0];
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_PHYS_ADDR <= '0;
            O_IRQ_VEC   <= 1'b0;
            O_NMI_VEC   <= 1'b0;
        end else if (I_CE) begin
            O_PHYS_ADDR <= next_phys;
            O_IRQ_VEC   <= next_irq;
            O_NMI_VEC   <= next_nmiv;
        end
    end

    // pin synchronisers
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            nmi_sync <= 3'h7;
            rst_sync <= 3'h0;
            tst_sync <= 3'h0;
            nmi_lvl  <= 1'b1;
            rst_lvl  <= 1'b0;
        end else if (I_CE) begin
            nmi_sync <= {nmi_sync[1:0], I_NMI_N};
            rst_sync <= {rst_sync[1:0], I_RESET_N};
            tst_sync <= {tst_sync[1:0], I_TEST};
            if (nmi_agree) begin
                nmi_lvl <= nmi_sync[1];
            end
            if (rst_agree) begin
                rst_lvl <= rst_sync[1];
            end
        end
    end

    // nmi request, set wins over acknowledge
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_NMI_REQ <= 1'b0;
        end else if (I_CE) begin
            if (nmi_fall) begin
                O_NMI_REQ <= 1'b1;
            end else if (I_NMI_ACK) begin
                O_NMI_REQ <= 1'b0;
            end
        end
    end

    // mode: test level caught when the filtered reset pin is seen high again
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            mode <= ST_RESET;
        end else if (I_CE) begin
            unique case (mode)
                ST_RESET: if (rst_lvl && rst_agree && rst_sync[1]) begin
                    mode <= (tst_agree && tst_sync[1]) ? ST_PROG : ST_RUN;
                end
                ST_RUN, ST_PROG: if (!rst_lvl) begin
                    mode <= ST_RESET;
                end
                default: mode <= ST_RESET;
            endcase
        end
    end

    assign O_CORE_RESET = (mode == ST_RESET);
    assign O_PROG_MODE  = (mode == ST_PROG);

    // six-level return stack
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            stack_cnt   <= 3'h0;
            O_STACK_OVF <= 1'b0;
            O_STACK_UNF <= 1'b0;
        end else if (I_CE) begin
            O_STACK_OVF <= I_STACK.push && (stack_cnt == STACK_CNT_W1);
            O_STACK_UNF <= do_pop ? 1'b0 : (I_STACK.pop && !I_STACK.push && stack_cnt == 3'h0);
            if (do_push) begin
                stack_cnt <= stack_cnt + 3'h1;
            end else if (do_pop) begin
                stack_cnt <= stack_cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_CE && do_push) begin
            stack_mem[stack_cnt] <= I_STACK.data;
        end
    end

    assign O_STACK_TOP = (stack_cnt == 3'h0) ? '0 : stack_mem[stack_cnt - 3'h1];

    // nmi pin steady high, then steady low long enough to pass the filter
    sequence s_pin_high;
        (I_CE && I_NMI_N) [*4];
    endsequence
    sequence s_pin_low;
        (I_CE && !I_NMI_N) [*4];
    endsequence

    property p_phys;
        @(posedge I_MCLK) disable iff (I_RST)
        I_CE |=> O_PHYS_ADDR[OFS_W-1:0] == $past(I_PROGRAM_COUNTER[OFS_W-1:0]);
    endproperty
    property p_nmi_filter;
        @(posedge I_MCLK) disable iff (I_RST)
        s_pin_high ##1 s_pin_low |=> O_NMI_REQ;
    endproperty

    // page mapping and select
    a_phys_offset: assert property (p_phys) else $error("offset not passed");
    a_static_top: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && program_counter_top_bit |=> O_PHYS_ADDR[12:11] == STATIC_PAGE)
        else $error("top half not static");
    a_lower_sel: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && !program_counter_top_bit |=> O_PHYS_ADDR[12:11] == $past(program_page_select))
        else $error("lower window wrong page");
    a_sel_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && sel_wr |=> program_page_select == $past(I_DWRITE.data[1:0]))
        else $error("page select not written");
    a_sel_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
        !sel_wr |=> $stable(program_page_select))
        else $error("page select changed");

    // nmi request
    a_nmi_set: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && nmi_fall |=> O_NMI_REQ) else $error("nmi edge lost");
    a_nmi_filter: assert property (p_nmi_filter) else $error("filtered nmi edge lost");
    a_nmi_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_NMI_ACK && !nmi_fall |=> !O_NMI_REQ)
        else $error("nmi request not cleared");

    // vectors, stack and reset
    a_irq_vec: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_PROGRAM_COUNTER == IRQ_VEC_LO |=> O_IRQ_VEC && !O_NMI_VEC)
        else $error("irq vector miss");
    a_nmi_vec: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_PROGRAM_COUNTER == NMI_VEC_LO |=> O_NMI_VEC && !O_IRQ_VEC)
        else $error("nmi vector miss");
    a_stack_max: assert property (@(posedge I_MCLK) disable iff (I_RST)
        stack_cnt <= STACK_CNT_W1) else $error("stack too deep");
    a_stack_full: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && I_STACK.push && stack_cnt == STACK_CNT_W1 |=> O_STACK_OVF
        && stack_cnt == STACK_CNT_W1) else $error("full stack overwritten");
    a_reset_pin: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_CE && mode != ST_RESET && !rst_lvl |=> O_CORE_RESET)
        else $error("reset pin ignored");
endmodule // ppd_decoder

// ===== verif/ppd_core_model.sv
// core side model: program counter, data writes, stack strobes, nmi ack
// assumes the bench calls its tasks; outputs change 1 ns after a rising edge
`timescale 1ns/10ps
module ppd_core_model
    import ppd_pkg::*;
(
    input  wire logic                      i_clk,
    output logic [ppd_pkg::PROG_CNT_W-1:0] o_prog_cnt,
    output ppd_pkg::ppd_dwrite_t           o_dw,
    output ppd_pkg::ppd_stack_req_t        o_st,
    output logic                           o_ack
);
    import ppd_pkg::*;
    initial {o_prog_cnt, o_dw, o_st, o_ack} = '0;
    task step();
        @(posedge i_clk);
        #1;
    endtask
    task go(input logic [11:0] a);
        step();
        o_prog_cnt = a;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        step();
        o_dw = {1'b1, a, d};
        step();
        o_dw = '0;
    endtask
    task stk(input logic u, input logic o, input logic [11:0] d);
        step();
        o_st = {u, o, d};
        step();
        o_st = '0;
    endtask
    task ack();
        step();
        o_ack = 1'b1;
        step();
        o_ack = 1'b0;
    endtask
    // page change only from the static page
    task set_page(input logic [1:0] p);
        go(12'h800);
        wr(PAGE_SEL_ADDR, {6'h0, p});
    endtask
endmodule // ppd_core_model

// ===== verif/tb_program_space_page_decoder.sv
// testbench for the program space page decoder
// assumes ppd_core_model drives the core side; pins are driven here
`timescale 1ns/10ps
module tb_program_space_page_decoder;
    import ppd_pkg::*;
    logic I_MCLK = 0, I_RST = 1, I_NMI_N = 1, I_RESET_N = 1, I_TEST = 0, I_CE = 1;
    logic [PROG_CNT_W-1:0] prog_cnt, top;
    logic [PHYS_W-1:0] pa;
    ppd_dwrite_t       dw;
    ppd_stack_req_t    st;
    logic              ack, irq, nmi, req, crst, prog, ovf, unf;
    int                n_fail = 0, n_checks = 0, i;
    always #5 I_MCLK = ~I_MCLK;
    ppd_core_model core (.i_clk(I_MCLK), .o_prog_cnt(prog_cnt),
        .o_dw(dw), .o_st(st), .o_ack(ack));
    ppd_decoder uut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(I_CE), .I_PROGRAM_COUNTER(prog_cnt),
        .I_DWRITE(dw), .I_STACK(st), .I_NMI_N(I_NMI_N), .I_RESET_N(I_RESET_N),
        .I_TEST(I_TEST), .I_NMI_ACK(ack), .O_PHYS_ADDR(pa), .O_IRQ_VEC(irq),
        .O_NMI_VEC(nmi), .O_NMI_REQ(req), .O_CORE_RESET(crst), .O_PROG_MODE(prog),
        .O_STACK_TOP(top), .O_STACK_OVF(ovf), .O_STACK_UNF(unf));
    task chk(input string n, input logic [12:0] g, input logic [12:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wait_rst(input logic v);
        for (i = 0; i < 16 && crst !== v; i++) core.step();
        chk("core_reset", crst, v);
        if (crst !== v) stop_test();
    endtask
    task t_pages();
        for (int p = 0; p < 4; p++) begin
            core.set_page(p[1:0]);
            core.wr(8'hcb, 8'h03);
            core.go(12'h123);
            core.step();
            chk("phys_lo", pa, {p[1:0], 11'h123});
            core.go(12'h923);
            core.step();
            chk("phys_hi", pa, {STATIC_PAGE, 11'h123});
        end
        $display("pages done");
    endtask
    task t_freeze();
        I_CE = 1'b0;
        core.go(12'h345);
        core.wr(PAGE_SEL_ADDR, 8'h02);
        chk("ce_hold", pa, {STATIC_PAGE, 11'h123});
        I_CE = 1'b1;
        core.step();
        chk("ce_run", pa, {2'h3, 11'h345});
        $display("freeze done");
    endtask
    task t_vec();
        logic [11:0] a[6] = '{12'hfef, 12'hff0, 12'hff7, 12'hff8, 12'hffc, 12'hffd};
        logic [1:0]  e[6] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1};
        for (int k = 0; k < 6; k++) begin
            core.go(a[k]);
            core.step();
            chk("vectors", {irq, nmi}, e[k]);
        end
        $display("vectors done");
    endtask
    task t_nmi();
        chk("nmi_idle", req, 1'b0);
        I_NMI_N = 1'b0;
        for (i = 0; i < 8 && req !== 1'b1; i++) core.step();
        chk("nmi_set", req, 1'b1);
        if (req !== 1'b1) stop_test();
        I_NMI_N = 1'b1;
        core.ack();
        core.step();
        chk("nmi_clear", req, 1'b0);
        $display("nmi done");
    endtask
    task t_stack();
        for (int k = 0; k < 7; k++) begin
            core.stk(1'b1, 1'b0, 12'h100 + k[11:0]);
            chk("push_ovf", ovf, k == 6);
        end
        chk("top_full", top, 12'h105);
        for (int k = 5; k >= -1; k--) begin
            core.stk(1'b0, 1'b1, 12'h0);
            chk("pop_unf", unf, k < 0);
            chk("top", top, k > 0 ? 12'h100 + k - 1 : 12'h0);
        end
        core.stk(1'b1, 1'b1, 12'h0aa);
        chk("top_both", top, 12'h0aa);
        chk("unf_both", unf, 1'b0);
        core.stk(1'b0, 1'b1, 12'h0);
        chk("top_drained", top, 12'h0);
        $display("stack done");
    endtask
    task t_reset();
        I_RESET_N = 1'b0;
        wait_rst(1'b1);
        I_TEST = 1'b1;
        repeat (4) core.step();
        I_RESET_N = 1'b1;
        wait_rst(1'b0);
        chk("prog_mode", prog, 1'b1);
        I_RESET_N = 1'b0;
        I_TEST = 1'b0;
        wait_rst(1'b1);
        repeat (4) core.step();
        I_RESET_N = 1'b1;
        wait_rst(1'b0);
        chk("prog_mode", prog, 1'b0);
        $display("reset done");
    endtask
    initial begin
        repeat (8) @(posedge I_MCLK);
        #1 I_RST = 1'b0;
        wait_rst(1'b0);
        t_pages();
        t_freeze();
        t_vec();
        t_nmi();
        t_stack();
        t_reset();
        stop_test();
    end
endmodule // tb_program_space_page_decoder
